// ===== verilog/sdci_pkg.sv
// constants and types shared by both ends of the serial converter link
package sdci_pkg;
	localparam int WORD_BITS  = 16;            // bits in one serial word
	localparam int CODE_BITS  = 12;            // converter code width
	localparam int CMD_BITS   = 3;             // command field width
	localparam int CMD_MSB    = 15;            // command field top bit
	localparam int CMD_LSB    = 13;            // command field bottom bit
	localparam int CODE_MSB   = 12;            // code field top bit
	localparam int CODE_LSB   = 1;             // code field bottom bit
	localparam int SUB_POS    = 0;             // trailing sub-bit position
	localparam int CNT_W      = 5;             // bit counter width
	localparam logic [CNT_W-1:0] CNT_FULL = 5'h10; // count of a whole word
	localparam logic [CODE_BITS-1:0] CODE_RST = 12'h000; // power-up code
	// low two command bits select the action; shutdown and no-op use all three
	localparam logic [1:0] LOW_LOAD_BOTH  = 2'h0;
	localparam logic [1:0] LOW_LOAD_INPUT = 2'h1;
	localparam logic [1:0] LOW_UPDATE     = 2'h2;
	localparam logic [CMD_BITS-1:0] CMD_SHUTDOWN = 3'h7;
	localparam logic [CMD_BITS-1:0] CMD_NOP      = 3'h3;
	// serial timing limits in ns
	localparam int T_CLK_PERIOD_NS = 100;     // least serial clock period
	localparam int T_CSS_NS        = 40;      // select fall to clock rise
	localparam int T_CSW_NS        = 100;     // least select high time
	localparam int SYS_PERIOD_NS   = 5;       // system clock period
	localparam int HALF_CYC = (T_CLK_PERIOD_NS / 2 + SYS_PERIOD_NS - 1)
		/ SYS_PERIOD_NS;
	localparam int CSS_CYC = (T_CSS_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam int CSW_CYC = (T_CSW_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	// decoded action of a finished word
	typedef enum logic [2:0] {
		SDCI_ACT_NONE,
		SDCI_ACT_LOAD_BOTH,
		SDCI_ACT_LOAD_INPUT,
		SDCI_ACT_UPDATE,
		SDCI_ACT_SHUTDOWN
	} sdci_act_type;

	// decode a command field into its action
	function automatic sdci_act_type sdci_decode(
		input logic [CMD_BITS-1:0] cmd
	);
		sdci_act_type act;
		act = SDCI_ACT_NONE;
		if (cmd == CMD_SHUTDOWN) begin
			act = SDCI_ACT_SHUTDOWN;
		end else if (cmd == CMD_NOP) begin
			act = SDCI_ACT_NONE;
		end else if (cmd[1:0] == LOW_LOAD_BOTH) begin
			act = SDCI_ACT_LOAD_BOTH;
		end else if (cmd[1:0] == LOW_LOAD_INPUT) begin
			act = SDCI_ACT_LOAD_INPUT;
		end else if (cmd[1:0] == LOW_UPDATE) begin
			act = SDCI_ACT_UPDATE;
		end
		return act;
	endfunction
endpackage

// ===== verilog/sdci_link_if.sv
// three-wire serial link between host and converter
`timescale 1ns/100ps
interface sdci_link_if;
	logic cs_n;   // chip select, active low
	logic sclk;   // serial clock made by the host
	logic sdata;  // serial data, msb first
	modport host_mp   (output cs_n, output sclk, output sdata);
	modport device_mp (input cs_n, input sclk, input sdata);
endinterface

// ===== verilog/sdci_device.sv
// converter end: serial shift register, command decode, double buffer
`timescale 1ns/100ps
module sdci_device
	import sdci_pkg::*;
(
	// clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_n_i,
	// serial link
	sdci_link_if.device_mp            link,
	// converter side
	output logic [CODE_BITS-1:0]      input_code_o,
	output logic [CODE_BITS-1:0]      conv_code_o,
	output logic                      shutdown_o,
	output logic                      word_done_o
);
	////////////////////////////////////////////////////////////////////
	// how a word travels through this end
	// - every pin crosses into the system clock through two flops
	// - a rising serial clock seen while selected shifts one bit in
	// - the bit count saturates one past a word, so a long frame is
	//   told apart from an exact one without a wider counter
	// - at the select rising edge the word is decoded and acted on,
	//   at the third system clock edge after the pin itself rose
	// - a frame of any other length is dropped whole
	// - the register outputs hold until the next accepted word or reset
	// hazard: select and clock moving in one host cycle is safe, since
	//   the count is read before the deselect clears it
	// limitation: each serial clock half must span three system cycles
	// or more, else the synchroniser can swallow an edge
	// trade-off: oversampling costs a few cycles of latency but keeps
	// the whole end in the one system clock domain

	////////////////////////////////////////////////////////////////////
	// pin synchronisers: two flops before any logic reads a pin
	localparam int PIN_CNT  = 3;      // pins on the link
	localparam int PIN_CS   = 2;      // slot of the select pin
	localparam int PIN_SCLK = 1;      // slot of the serial clock pin
	localparam int PIN_DATA = 0;      // slot of the serial data pin
	// idle levels: deselected, clock low, data low; starting every
	// stage at its pin's idle level keeps reset release from faking
	// an edge on the clock or the select
	localparam logic [PIN_CNT-1:0] PIN_IDLE = 3'h4;

	logic [PIN_CNT-1:0] pin_raw;     // pins gathered in slot order
	logic [PIN_CNT-1:0] cs_meta_q;   // first stage, read only by second
	logic [PIN_CNT-1:0] cs_sync_q;   // {cs_n, sclk, sdata} synced
	logic               sclk_prev_q; // last synced serial clock
	logic               cs_prev_q;   // last synced select

	assign pin_raw[PIN_CS]   = link.cs_n;  // select, active low
	assign pin_raw[PIN_SCLK] = link.sclk;  // serial clock from the host
	assign pin_raw[PIN_DATA] = link.sdata; // serial data, msb first

	// one two-flop synchroniser per pin; all three share one latency,
	// so data and clock stay lined up after the crossing
	genvar g;
	generate
		for (g = 0; g < PIN_CNT; g = g + 1) begin : g_sync
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					cs_meta_q[g] <= PIN_IDLE[g];
					cs_sync_q[g] <= PIN_IDLE[g];
				end else begin
					cs_meta_q[g] <= pin_raw[g];    // may go metastable
					cs_sync_q[g] <= cs_meta_q[g];  // settled copy
				end
			end
		end
	endgenerate

	// edge history for select and clock, idle levels after reset
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_prev_q <= PIN_IDLE[PIN_SCLK];
			cs_prev_q   <= PIN_IDLE[PIN_CS];
		end else begin
			sclk_prev_q <= cs_sync_q[PIN_SCLK];
			cs_prev_q   <= cs_sync_q[PIN_CS];
		end
	end

	logic sel_low;   // interface enabled
	logic sclk_rise; // serial clock rising edge
	logic cs_rise;   // end of a word
	assign sel_low   = !cs_sync_q[PIN_CS];
	assign sclk_rise = cs_sync_q[PIN_SCLK] && !sclk_prev_q;
	assign cs_rise   = cs_sync_q[PIN_CS] && !cs_prev_q;

	////////////////////////////////////////////////////////////////////
	// shift register and bit count
	logic [WORD_BITS-1:0] shift_q; // incoming word, msb first
	logic [CNT_W-1:0]     count_q; // bits taken, saturates past a word

	// sample data on each rising clock while selected
	// the register keeps shifting past sixteen bits, so after a long
	// frame it holds the last sixteen; the count marks such a frame bad
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_q <= '0;
		end else if (sel_low && sclk_rise) begin
			shift_q <= {shift_q[WORD_BITS-2:0], cs_sync_q[PIN_DATA]};
		end
	end

	// count resets while deselected so each frame starts clean
	// a frame cut short leaves a count below a word, so the select
	// edge that ends it finds no whole word to act on
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_q <= '0;
		end else if (!sel_low) begin
			count_q <= '0;
		end else if (sclk_rise && count_q <= CNT_FULL) begin
			// counts one past a word so extra bits mark it bad
			count_q <= count_q + CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////
	// word decode at the select rising edge
	// word_ok is the only strobe that changes state; everything else in
	// this end only watches the link
	logic         word_ok;  // exactly sixteen bits clocked
	sdci_act_type act;      // decoded action
	logic [CODE_BITS-1:0] code_field; // code bits of the word
	assign word_ok    = cs_rise && (count_q == CNT_FULL);
	assign act        = sdci_decode(shift_q[CMD_MSB:CMD_LSB]);
	assign code_field = shift_q[CODE_MSB:CODE_LSB];
	// sub-bit at SUB_POS is ignored; host keeps it zero
	// decode is combinational on the held shift register; the word
	// stands still once select is high, since no clock edge is taken
	// then, so the decode is settled when word_ok fires

	////////////////////////////////////////////////////////////////////
	// double buffer: input register feeds converter register
	// commands act once per accepted word and never in between, so a
	// stray clock with select high cannot disturb the stored codes

	// input register
	// shutdown does not touch it, so a later update can recall it
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			input_code_o <= CODE_RST;
		end else if (word_ok) begin
			case (act)
				SDCI_ACT_LOAD_BOTH,
				SDCI_ACT_LOAD_INPUT: begin
					input_code_o <= code_field;
				end
				default: begin
					input_code_o <= input_code_o;
				end
			endcase
		end
	end

	// converter register
	// update copies the input register as it stood before this edge,
	// which is the code of the last load, not of the update word
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			conv_code_o <= CODE_RST;
		end else if (word_ok) begin
			case (act)
				SDCI_ACT_LOAD_BOTH: begin
					conv_code_o <= code_field;
				end
				SDCI_ACT_UPDATE: begin
					conv_code_o <= input_code_o;
				end
				default: begin
					conv_code_o <= conv_code_o;
				end
			endcase
		end
	end

	// shutdown state; interface stays live throughout
	// load-input and no-op words leave it as it is; only a word that
	// changes the converter output brings the end out of shutdown
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shutdown_o <= 1'b0;
		end else if (word_ok) begin
			case (act)
				SDCI_ACT_SHUTDOWN: begin
					shutdown_o <= 1'b1;
				end
				SDCI_ACT_LOAD_BOTH,
				SDCI_ACT_UPDATE: begin
					shutdown_o <= 1'b0;
				end
				default: begin
					shutdown_o <= shutdown_o;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// status
	// one-cycle pulse when a whole word was accepted
	// it rises with the register change, any command, the no-op too;
	// discarded frames never raise it
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			word_done_o <= 1'b0;
		end else begin
			word_done_o <= word_ok;
		end
	end
endmodule

// ===== verilog/sdci_host.sv
// host end: sends one sixteen-bit word per request over the link
`timescale 1ns/100ps
module sdci_host
	import sdci_pkg::*;
#(
	parameter int HALF_CYCLES = HALF_CYC, // one less than the sys clocks per clock half
	parameter int SETUP_CYCLES = CSS_CYC, // select fall to first rise
	parameter int GAP_CYCLES  = CSW_CYC   // select high after a word
)(
	// clock and reset
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_n_i,
	// user request
	input  wire logic                 req_valid_i,
	input  wire logic [CMD_BITS-1:0]  req_cmd_i,
	input  wire logic [CODE_BITS-1:0] req_code_i,
	output logic                      req_ready_o,
	output logic                      done_o,
	// serial link
	sdci_link_if.host_mp              link
);
	typedef enum logic [1:0] {
		SDCI_H_IDLE,
		SDCI_H_SETUP,
		SDCI_H_SHIFT,
		SDCI_H_GAP
	} sdci_hstate_type;

	sdci_hstate_type      state_q;
	logic [WORD_BITS-1:0] word_q;  // word being sent, msb at top
	logic [CNT_W-1:0]     bits_q;  // bits still to send
	logic [7:0]           timer_q; // cycle timer inside a phase
	logic                 sclk_q;  // serial clock out
	logic                 cs_n_q;  // select out

	assign req_ready_o = (state_q == SDCI_H_IDLE);
	assign link.cs_n   = cs_n_q;
	assign link.sclk   = sclk_q;
	assign link.sdata  = word_q[WORD_BITS-1];

	////////////////////////////////////////////////////////////////////
	// sequencer: one select per word and sixteen bits
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= SDCI_H_IDLE;
			word_q  <= '0;
			bits_q  <= '0;
			timer_q <= '0;
			sclk_q  <= 1'b0;
			cs_n_q  <= 1'b1;
			done_o  <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (state_q)
				SDCI_H_IDLE: begin
					if (req_valid_i) begin
						// sub-bit always zero
						word_q  <= {req_cmd_i, req_code_i, 1'b0};
						bits_q  <= CNT_FULL;
						timer_q <= 8'(SETUP_CYCLES);
						cs_n_q  <= 1'b0;     // select before clock
						state_q <= SDCI_H_SETUP;
					end
				end
				SDCI_H_SETUP: begin
					if (timer_q == 8'h00) begin
						timer_q <= 8'(HALF_CYCLES);
						state_q <= SDCI_H_SHIFT;
					end else begin
						timer_q <= timer_q - 8'h01;
					end
				end
				SDCI_H_SHIFT: begin
					// halves held long enough to respect the rate
					if (timer_q != 8'h00) begin
						timer_q <= timer_q - 8'h01;
					end else if (!sclk_q) begin
						sclk_q  <= 1'b1;     // device samples here
						timer_q <= 8'(HALF_CYCLES);
						bits_q  <= bits_q - CNT_W'(1);
					end else if (bits_q != '0) begin
						sclk_q  <= 1'b0;
						word_q  <= {word_q[WORD_BITS-2:0], 1'b0};
						timer_q <= 8'(HALF_CYCLES);
					end else begin
						sclk_q  <= 1'b0;
						cs_n_q  <= 1'b1;     // word acted on here
						timer_q <= 8'(GAP_CYCLES);
						state_q <= SDCI_H_GAP;
					end
				end
				SDCI_H_GAP: begin
					if (timer_q == 8'h00) begin
						done_o  <= 1'b1;
						state_q <= SDCI_H_IDLE;
					end else begin
						timer_q <= timer_q - 8'h01;
					end
				end
				default: begin
					state_q <= SDCI_H_IDLE;
				end
			endcase
		end
	end
endmodule

// ===== verification/sdci_link_sva.sv
// wire checks on the host-to-converter link
`timescale 1ns/100ps
module sdci_link_sva
	import sdci_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// link wires
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdata
);
	logic       sclk_q;                // clock level one cycle ago
	logic [4:0] bit_q;                 // clock rises in this word
	logic [5:0] len_q;                 // cycles the clock level stood
	logic [5:0] hi_q;                  // cycles select stood high
	wire        rise = sclk & ~sclk_q; // clock rise seen this cycle
	////////////////////////////////////////////////////////////////
	// len_q and hi_q saturate so that long idle spells cannot wrap
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_q <= 1'b0;
			bit_q  <= 5'h00;
			len_q  <= 6'h3f;
			hi_q   <= 6'h3f;
		end else begin
			sclk_q <= sclk;
			bit_q  <= cs_n ? 5'h00 : bit_q + {4'h0, rise};
			len_q  <= (sclk != sclk_q) ? 6'h01 : len_q + {5'h0, ~&len_q};
			hi_q   <= cs_n ? hi_q + {5'h0, ~&hi_q} : 6'h00;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	a_idle_clock_low: assert property (cs_n |-> !sclk)
		else $error("serial clock high while deselected");
	a_select_setup: assert property (
		rise && bit_q == 5'h00 |-> !$past(cs_n, CSS_CYC))
		else $error("select fell too late before first clock");
	a_first_rise_soon: assert property (
		$fell(cs_n) |-> ##[1:60] rise)
		else $error("no clock rise after select fell");
	a_half_width: assert property (
		(sclk != sclk_q) && !cs_n |-> len_q >= 6'(HALF_CYC))
		else $error("serial clock half too short");
	a_sixteen_bits: assert property ($rose(cs_n) |-> bit_q == CNT_FULL)
		else $error("word not sixteen bits long");
	a_sub_bit_zero: assert property (
		rise && !cs_n && bit_q == 5'h0f |-> !sdata)
		else $error("trailing bit not zero");
	a_data_stable: assert property (
		sclk && sclk_q && !cs_n |-> $stable(sdata))
		else $error("data moved while clock high");
	a_select_gap: assert property ($fell(cs_n) |-> hi_q >= 6'(CSW_CYC))
		else $error("select high time too short");
	a_word_closes: assert property (
		$fell(cs_n) |-> ##[300:600] $rose(cs_n))
		else $error("word did not close in time");
endmodule

// ===== verification/tb_top.sv
// bench: host and converter joined, plus a raw link for bad words
`timescale 1ns/100ps
module tb_top;
	import sdci_pkg::*;
	logic        sys_clk, rst_n;        // clock, reset
	logic        req_valid, req_ready;  // host handshake
	logic        done;                  // host word finished
	logic [2:0]  req_cmd;               // host command
	logic [11:0] req_code, in_a, cv_a;  // code, first converter
	logic [11:0] in_b, cv_b;            // second converter
	logic        sd_a, sd_b, wd_a, wd_b; // shutdown, word done
	logic [24:0] q_a[$], q_b[$];        // notes {input, conv, shutdown}
	logic [24:0] m_a, m_b;              // reference state
	int          fails, compares, seed, i;
	sdci_link_if link_a ();
	sdci_link_if link_b ();
	sdci_host u_sdci_host (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
		.req_valid_i(req_valid), .req_cmd_i(req_cmd), .req_code_i(req_code),
		.req_ready_o(req_ready), .done_o(done), .link(link_a));
	sdci_device u_sdci_device (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
		.link(link_a), .input_code_o(in_a), .conv_code_o(cv_a),
		.shutdown_o(sd_a), .word_done_o(wd_a));
	// second converter fed by the bench, for rule-breaking words
	sdci_device u_sdci_device_2 (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
		.link(link_b), .input_code_o(in_b), .conv_code_o(cv_b),
		.shutdown_o(sd_b), .word_done_o(wd_b));
	sdci_link_sva u_sdci_link_sva (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
		.cs_n(link_a.cs_n), .sclk(link_a.sclk), .sdata(link_a.sdata));
	always #2.5 sys_clk = ~sys_clk;
	// reference effect of one word
	function automatic logic [24:0] apply(logic [24:0] m, logic [2:0] c,
		logic [11:0] d);
		logic [11:0] n;
		logic [11:0] v;
		logic s;
		{n, v, s} = m;
		if (c == 3'h7) s = 1'b1;
		else if (c[1:0] == 2'h0) {n, v, s} = {d, d, 1'b0};
		else if (c[1:0] == 2'h1) n = d;
		else if (c[1:0] == 2'h2) {v, s} = {n, 1'b0};
		return {n, v, s}; // no-op leaves all
	endfunction
	task automatic chk(logic [24:0] seen, logic [24:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic take(ref logic [24:0] q[$], input logic [24:0] seen);
		if (q.size() == 0) chk(seen, 25'hz);
		else chk(seen, q.pop_front());
	endtask
	task automatic give_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// watcher: sample settled outputs away from the rising edge
	always @(negedge sys_clk) begin
		if (wd_a === 1'b1) take(q_a, {in_a, cv_a, sd_a});
		if (wd_b === 1'b1) take(q_b, {in_b, cv_b, sd_b});
	end
	// one word through the host end
	task automatic send(logic [2:0] c, logic [11:0] d);
		int n;
		@(negedge sys_clk);
		chk({24'h0, req_ready}, 25'h1); // idle host takes requests
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_cmd <= c;
		req_code <= d;
		m_a = apply(m_a, c, d);
		q_a.push_back(m_a);
		@(posedge sys_clk);
		req_valid <= 1'b0;
		@(negedge sys_clk);
		chk({24'h0, req_ready}, 25'h0); // busy while word runs
		for (n = 0; n < 2000 && done !== 1'b1; n++) @(negedge sys_clk);
		chk({24'h0, done}, 25'h1);
	endtask
	// raw word on the second link; bench makes its own serial clock
	task automatic bang(logic [16:0] w, int nb, logic sel);
		int k;
		@(negedge sys_clk);
		#1 link_b.cs_n = ~sel;
		#48;
		for (k = nb - 1; k >= 0; k--) begin
			link_b.sdata = w[k];
			#32 link_b.sclk = 1'b1;
			#32 link_b.sclk = 1'b0;
		end
		#32 chk({in_b, cv_b, sd_b}, m_b); // still old state
		link_b.cs_n = 1'b1;
		link_b.sdata = ~link_b.sdata; // released line: no stale level
		#200;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{sys_clk, rst_n, req_valid, req_cmd, req_code} = 0;
		{link_b.cs_n, link_b.sclk, link_b.sdata} = 3'h4;
		{fails, compares, m_a, m_b} = 0;
		seed = 32'h9ab7;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		chk({in_a, cv_a, sd_a}, 25'h0);
		chk({in_b, cv_b, sd_b}, 25'h0);
		$display("test reset done");
		for (i = 0; i < 8; i++) send(3'(i), 12'($random(seed)));
		send(3'h5, 12'($random(seed))); // input loads, still shut down
		send(3'h2, 12'h000); // recall
		for (i = 0; i < 12; i++) send(3'($random(seed)), 12'($random(seed)));
		$display("test host words done");
		q_b.push_back(apply(m_b, 3'h1, 12'h5a5));
		bang({4'h1, 12'h5a5, 1'b0}, 16, 1'b1);
		m_b = apply(m_b, 3'h1, 12'h5a5);
		bang({4'h0, 12'h0f0, 1'b0}, 15, 1'b1); // short word
		bang({4'h0, 12'h0f0, 1'b0}, 17, 1'b1); // long word
		bang({4'h0, 12'h0f0, 1'b0}, 16, 1'b0); // deselected
		q_b.push_back(apply(m_b, 3'h2, 12'h000));
		bang({4'h2, 12'h000, 1'b0}, 16, 1'b1);
		m_b = apply(m_b, 3'h2, 12'h000);
		chk(25'(q_a.size()), 25'h0); // every host word answered
		chk(25'(q_b.size()), 25'h0); // every raw word answered
		$display("test raw link done");
		give_verdict();
	end
	// watchdog
	initial begin
		#400000;
		fails++;
		give_verdict();
	end
endmodule
